// *** core/fcs_consts.svh ***
// How it works
// - all cycles writes except array/autoselect reads
// - array read is one plain read cycle
// - F0 reset returns device to read mode
// - autoselect fourth cycle is a read
// - top address bit low, cycles three/four
// - protect verify top bit picks sector half
// - bypass program only after bypass entry
// - bypass exit is 90 then 00
// - program is AA, 55, A0, data
// - chip erase is AA,55,80,AA,55,10
// - sector erase ends 30 at sector
// - autoselect AA,55,90 then read offset
// - secured region entry ends with 88
// - secured region exit ends 90, 00
// - CFI query is 98 to AA
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

`define FCS_ADDR_W      22
`define FCS_DATA_W      8

// unlock and command addresses (byte mode)
`define FCS_ADR_UNLK1   22'h00_0AAA
`define FCS_ADR_UNLK2   22'h00_0555
`define FCS_ADR_CFI     22'h00_00AA
`define FCS_ADR_ANY     22'h00_0000
`define FCS_ADR_PROT    16'h0004

// command data codes
`define FCS_D_UNLK1     8'hAA
`define FCS_D_UNLK2     8'h55
`define FCS_D_RESET     8'hF0
`define FCS_D_AUTOSEL   8'h90
`define FCS_D_SECENTER  8'h88
`define FCS_D_EXIT      8'h00
`define FCS_D_PROGRAM   8'hA0
`define FCS_D_BYPASS    8'h20
`define FCS_D_ERASE     8'h80
`define FCS_D_CHIP      8'h10
`define FCS_D_SECT      8'h30
`define FCS_D_SUSPEND   8'hB0
`define FCS_D_RESUME    8'h30
`define FCS_D_CFI       8'h98

// bus timing: times in ns, least times rounded up to whole cycles
`define FCS_CLK_NS      4
`define FCS_TWP_NS      35
`define FCS_TWPH_NS     30
`define FCS_TACC_NS     70
`define FCS_TWP_CYC     8'((`FCS_TWP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_TWPH_CYC    8'((`FCS_TWPH_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
// two extra cycles cover the data-input synchroniser
`define FCS_TRD_CYC     8'((`FCS_TACC_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS + 2)

`endif

// *** core/fcs_pkg.sv ***
`include "fcs_consts.svh"

package fcs_pkg;

  typedef enum logic [3:0] {
    OP_READ       = 4'h0,
    OP_RESET      = 4'h1,
    OP_AUTOSEL    = 4'h2,
    OP_PROT       = 4'h3,
    OP_SEC_ENTER  = 4'h4,
    OP_SEC_EXIT   = 4'h5,
    OP_PROGRAM    = 4'h6,
    OP_BYP_ENTER  = 4'h7,
    OP_BYP_PROG   = 4'h8,
    OP_BYP_RESET  = 4'h9,
    OP_CHIP_ERASE = 4'hA,
    OP_SECT_ERASE = 4'hB,
    OP_SUSPEND    = 4'hC,
    OP_RESUME     = 4'hD,
    OP_CFI        = 4'hE
  } fcs_op_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SETUP  = 5'b00010,
    ST_WRLOW  = 5'b00100,
    ST_WRHIGH = 5'b01000,
    ST_RDWAIT = 5'b10000
  } fcs_state_t;

  typedef struct packed {
    logic [`FCS_ADDR_W-1:0] addr;
    logic [`FCS_DATA_W-1:0] data;
    logic                   rd;
    logic                   last;
  } fcs_step_t;

  typedef struct packed {
    fcs_state_t             st;
    fcs_op_t                op;
    logic [2:0]             step;
    logic [7:0]             cnt;
    logic [`FCS_ADDR_W-1:0] cAddr;
    logic [`FCS_DATA_W-1:0] cData;
    logic                   bypass;
    logic                   rspValid;
    logic                   rspErr;
    logic [`FCS_DATA_W-1:0] rspData;
    logic [`FCS_ADDR_W-1:0] fAddr;
    logic [`FCS_DATA_W-1:0] fDq;
    logic                   dqOeN;
    logic                   ceN;
    logic                   weN;
    logic                   oeN;
    logic                   last;
    logic [`FCS_DATA_W-1:0] sync1;
    logic [`FCS_DATA_W-1:0] sync2;
  } fcs_regs_t;

endpackage : fcs_pkg

// *** core/fcs_host.sv ***
`include "fcs_consts.svh"

module fcs_host (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   cmdValid,
  output logic                        cmdReady,
  input  wire fcs_pkg::fcs_op_t       cmdOp,
  input  wire logic [`FCS_ADDR_W-1:0] cmdAddr,
  input  wire logic [`FCS_DATA_W-1:0] cmdData,
  output logic                        rspValid,
  output logic                        rspErr,
  output logic [`FCS_DATA_W-1:0]      rspData,
  output logic                        bypassMode,
  output logic [`FCS_ADDR_W-1:0]      flashAddr,
  output logic [`FCS_DATA_W-1:0]      flashDqOut,
  output logic                        flashDqOe_n,
  input  wire logic [`FCS_DATA_W-1:0] flashDqIn,
  output logic                        flashCe_n,
  output logic                        flashWe_n,
  output logic                        flashOe_n
);

  fcs_pkg::fcs_regs_t r;
  fcs_pkg::fcs_regs_t nx;
  fcs_pkg::fcs_step_t cur;

  // one bus cycle of a command sequence, chosen by operation and step index
  function automatic fcs_pkg::fcs_step_t stepOf(
    input fcs_pkg::fcs_op_t       op,
    input logic [2:0]             idx,
    input logic [`FCS_ADDR_W-1:0] a,
    input logic [`FCS_DATA_W-1:0] d
  );
    fcs_pkg::fcs_step_t s;
    logic [`FCS_ADDR_W-1:0] sect;
    s = '0;
    sect = {a[21:16], 16'h0000};
    // shared two-write unlock prefix
    if (idx == 3'd0) begin
      s.addr = `FCS_ADR_UNLK1;
      s.data = `FCS_D_UNLK1;
    end else if (idx == 3'd1) begin
      s.addr = `FCS_ADR_UNLK2;
      s.data = `FCS_D_UNLK2;
    end else begin
      s.addr = `FCS_ADR_UNLK1;
    end
    unique case (op)
      fcs_pkg::OP_READ: begin
        s = '{addr: a, data: '0, rd: 1'b1, last: 1'b1};
      end
      fcs_pkg::OP_RESET: begin
        s = '{addr: `FCS_ADR_ANY, data: `FCS_D_RESET, rd: 1'b0, last: 1'b1};
      end
      fcs_pkg::OP_AUTOSEL, fcs_pkg::OP_PROT: begin
        if (idx == 3'd2) begin
          s.data = `FCS_D_AUTOSEL;
          if (op == fcs_pkg::OP_PROT) begin
            s.addr[21] = a[21];
          end
        end else if (idx == 3'd3) begin
          s.rd = 1'b1;
          // identity offsets keep the top bit low; verify reads the sector
          s.addr = (op == fcs_pkg::OP_PROT) ? {a[21:16], `FCS_ADR_PROT}
                                             : {6'h00, a[15:0]};
        end else if (idx == 3'd4) begin
          s.addr = `FCS_ADR_ANY;
          s.data = `FCS_D_RESET;
          s.last = 1'b1;
        end
      end
      fcs_pkg::OP_SEC_ENTER: begin
        if (idx == 3'd2) begin
          s.data = `FCS_D_SECENTER;
          s.last = 1'b1;
        end
      end
      fcs_pkg::OP_SEC_EXIT: begin
        if (idx == 3'd2) begin
          s.data = `FCS_D_AUTOSEL;
        end else if (idx == 3'd3) begin
          s.addr = `FCS_ADR_ANY;
          s.data = `FCS_D_EXIT;
          s.last = 1'b1;
        end
      end
      fcs_pkg::OP_PROGRAM: begin
        if (idx == 3'd2) begin
          s.data = `FCS_D_PROGRAM;
        end else if (idx == 3'd3) begin
          s.addr = a;
          s.data = d;
          s.last = 1'b1;
        end
      end
      fcs_pkg::OP_BYP_ENTER: begin
        if (idx == 3'd2) begin
          s.data = `FCS_D_BYPASS;
          s.last = 1'b1;
        end
      end
      fcs_pkg::OP_BYP_PROG: begin
        s.addr = (idx == 3'd0) ? `FCS_ADR_ANY : a;
        s.data = (idx == 3'd0) ? `FCS_D_PROGRAM : d;
        s.last = (idx == 3'd1);
      end
      fcs_pkg::OP_BYP_RESET: begin
        s.addr = `FCS_ADR_ANY;
        s.data = (idx == 3'd0) ? `FCS_D_AUTOSEL : `FCS_D_EXIT;
        s.last = (idx == 3'd1);
      end
      fcs_pkg::OP_CHIP_ERASE, fcs_pkg::OP_SECT_ERASE: begin
        if (idx == 3'd2) begin
          s.data = `FCS_D_ERASE;
        end else if (idx == 3'd3) begin
          s.data = `FCS_D_UNLK1;
        end else if (idx == 3'd4) begin
          s.addr = `FCS_ADR_UNLK2;
          s.data = `FCS_D_UNLK2;
        end else if (idx == 3'd5) begin
          s.last = 1'b1;
          if (op == fcs_pkg::OP_SECT_ERASE) begin
            s.addr = sect;
            s.data = `FCS_D_SECT;
          end else begin
            s.data = `FCS_D_CHIP;
          end
        end
      end
      fcs_pkg::OP_SUSPEND: begin
        s = '{addr: `FCS_ADR_ANY, data: `FCS_D_SUSPEND, rd: 1'b0, last: 1'b1};
      end
      fcs_pkg::OP_RESUME: begin
        s = '{addr: `FCS_ADR_ANY, data: `FCS_D_RESUME, rd: 1'b0, last: 1'b1};
      end
      default: begin
        // OP_CFI and the unused code 4'hF both issue the query
        s = '{addr: `FCS_ADR_CFI, data: `FCS_D_CFI, rd: 1'b0, last: 1'b1};
      end
    endcase
    return s;
  endfunction : stepOf

  // refuse commands the device would not honour in its current mode
  function automatic logic legal(input fcs_pkg::fcs_op_t op, input logic byp);
    logic ok;
    ok = 1'b1;
    if (op == fcs_pkg::OP_BYP_PROG || op == fcs_pkg::OP_BYP_RESET) begin
      ok = byp;
    end else if (byp) begin
      ok = (op == fcs_pkg::OP_READ) || (op == fcs_pkg::OP_RESET);
    end
    return ok;
  endfunction : legal

  assign cur = stepOf(r.op, r.step, r.cAddr, r.cData);

  // next-state logic for the whole controller
  always_comb begin
    nx = r;
    nx.rspValid = 1'b0;
    nx.sync1 = flashDqIn;
    nx.sync2 = r.sync1;
    unique case (r.st)
      fcs_pkg::ST_IDLE: begin
        if (cmdValid) begin
          if (legal(cmdOp, r.bypass)) begin
            nx.op = cmdOp;
            nx.cAddr = cmdAddr;
            nx.cData = cmdData;
            nx.step = 3'd0;
            nx.rspErr = 1'b0;
            nx.st = fcs_pkg::ST_SETUP;
          end else begin
            nx.rspValid = 1'b1;
            nx.rspErr = 1'b1;
          end
        end
      end
      fcs_pkg::ST_SETUP: begin
        // address and chip select settle a full cycle before the write strobe; on a read, output enable falls with them
        nx.fAddr = cur.addr;
        nx.ceN = 1'b0;
        nx.last = cur.last;
        if (cur.rd) begin
          nx.oeN = 1'b0;
          nx.dqOeN = 1'b1;
          nx.cnt = `FCS_TRD_CYC;
          nx.st = fcs_pkg::ST_RDWAIT;
        end else begin
          nx.fDq = cur.data;
          nx.dqOeN = 1'b0;
          nx.cnt = `FCS_TWP_CYC;
          nx.st = fcs_pkg::ST_WRLOW;
        end
      end
      fcs_pkg::ST_WRLOW: begin
        // address held through the fall, data held through the rise; the strobe
        // falls one cycle after entry, so the count runs to zero to give a full pulse
        nx.weN = 1'b0;
        nx.cnt = r.cnt - 8'd1;
        if (r.cnt == 8'd0) begin
          nx.weN = 1'b1;
          nx.cnt = `FCS_TWPH_CYC;
          nx.st = fcs_pkg::ST_WRHIGH;
        end
      end
      fcs_pkg::ST_WRHIGH: begin
        nx.cnt = r.cnt - 8'd1;
        if (r.cnt == 8'd1) begin
          nx.ceN = 1'b1;
          nx.dqOeN = 1'b1;
          nx.step = r.step + 3'd1;
          nx.st = r.last ? fcs_pkg::ST_IDLE : fcs_pkg::ST_SETUP;
          nx.rspValid = r.last;
          if (r.last && r.op == fcs_pkg::OP_BYP_ENTER) begin
            nx.bypass = 1'b1;
          end else if (r.last && (r.op == fcs_pkg::OP_BYP_RESET ||
                                  r.op == fcs_pkg::OP_RESET)) begin
            nx.bypass = 1'b0;
          end
        end
      end
      fcs_pkg::ST_RDWAIT: begin
        nx.cnt = r.cnt - 8'd1;
        if (r.cnt == 8'd1) begin
          nx.rspData = r.sync2;
          nx.oeN = 1'b1;
          nx.ceN = 1'b1;
          nx.step = r.step + 3'd1;
          nx.st = r.last ? fcs_pkg::ST_IDLE : fcs_pkg::ST_SETUP;
          nx.rspValid = r.last;
        end
      end
      default: begin
        nx.st = fcs_pkg::ST_IDLE;
      end
    endcase
  end

  // single state register; bus strobes idle high and data undriven after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.st <= fcs_pkg::ST_IDLE;
      r.op <= fcs_pkg::OP_READ;
      r.dqOeN <= 1'b1;
      r.ceN <= 1'b1;
      r.weN <= 1'b1;
      r.oeN <= 1'b1;
    end else begin
      r <= nx;
    end
  end

  assign cmdReady    = (r.st == fcs_pkg::ST_IDLE);
  assign rspValid    = r.rspValid;
  assign rspErr      = r.rspErr;
  assign rspData     = r.rspData;
  assign bypassMode  = r.bypass;
  assign flashAddr   = r.fAddr;
  assign flashDqOut  = r.fDq;
  assign flashDqOe_n = r.dqOeN;
  assign flashCe_n   = r.ceN;
  assign flashWe_n   = r.weN;
  assign flashOe_n   = r.oeN;

endmodule : fcs_host

// *** test/fcs_host_sva.sv ***
`include "fcs_consts.svh"

module fcs_host_sva (
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic             cmdValid,
  input wire logic             cmdReady,
  input wire fcs_pkg::fcs_op_t cmdOp,
  input wire logic             rspValid,
  input wire logic             rspErr,
  input wire logic             bypassMode,
  input wire logic [21:0]      flashAddr,
  input wire logic [7:0]       flashDqOut,
  input wire logic             flashDqOe_n,
  input wire logic             flashCe_n,
  input wire logic             flashWe_n,
  input wire logic             flashOe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic take;
  // a request counts only on the edge where ready is also high
  assign take = cmdValid && cmdReady;
  // one write of the reset code, then the answer
  sequence s_reset_write;
    ##2 (!flashCe_n && !flashDqOe_n && flashDqOut == 8'hF0 && flashAddr == 22'h00_0000)
    ##18 rspValid;
  endsequence
  sequence s_read_cycle;
    ##2 (!flashCe_n && !flashOe_n) ##20 (rspValid && !rspErr);
  endsequence
  sequence s_we_pulse;
    !flashWe_n [*8] ##1 flashWe_n;
  endsequence

  a_we_in_ce: assert property (!flashWe_n |-> !flashCe_n)
    else $error("write strobe outside chip select");
  a_addr_held: assert property (!flashCe_n && !$past(flashCe_n) |-> $stable(flashAddr))
    else $error("address moved during a bus cycle");
  a_we_width: assert property ($fell(flashWe_n) |=> s_we_pulse)
    else $error("write strobe width wrong");
  a_data_held: assert property ($rose(flashWe_n) |-> $stable(flashDqOut) && !flashDqOe_n)
    else $error("data not held at write strobe rise");
  a_read_quiet: assert property (!flashOe_n |-> flashDqOe_n && flashWe_n)
    else $error("host drives data during a read");
  a_reset_cmd: assert property (take && cmdOp == fcs_pkg::OP_RESET |-> s_reset_write)
    else $error("reset command not sent as one write");
  a_read_single: assert property (take && cmdOp == fcs_pkg::OP_READ |->
      (flashWe_n throughout s_read_cycle))
    else $error("array read not a single read cycle");
  a_byp_refuse: assert property (take && !bypassMode &&
      (cmdOp == fcs_pkg::OP_BYP_PROG || cmdOp == fcs_pkg::OP_BYP_RESET)
      |=> rspValid && rspErr && flashCe_n)
    else $error("bypass command not refused");
  a_bypass_set: assert property (take && !bypassMode &&
      cmdOp == fcs_pkg::OP_BYP_ENTER |-> ##[50:60] bypassMode)
    else $error("bypass mode not entered");
endmodule : fcs_host_sva

// *** test/fcs_flash_model.sv ***
module fcs_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5A,  // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'hC3,  // arbitrary value
  parameter logic [7:0] LOCK_CODE  = 8'h85
) (
  input  wire logic        ceN,
  input  wire logic        weN,
  input  wire logic        oeN,
  input  wire logic [21:0] addr,
  input  wire logic [7:0]  dq,
  output logic [7:0]       drv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [29:0] wq[$];
  logic [29:0] hist[3] = '{default: 30'h0};
  logic [21:0] aLat;
  logic        autoSel = 1'b0;
  logic        rd;
  logic [7:0]  val;
  logic [7:0]  last = 8'h00;
  logic [21:0] rdA  = 22'h00_0000;
  // address latched at the later of the two falling strobes
  always @(negedge weN or negedge ceN) begin
    if (!weN && !ceN) aLat = addr;
  end
  // data taken at whichever strobe rises first; only low address bits decode
  always @(posedge weN or posedge ceN) begin
    if (weN ^ ceN) begin
      wq.push_back({aLat, dq});
      hist = '{hist[1], hist[2], {aLat, dq}};
      autoSel = hist[0][19:0] == 20'hA_AAAA && hist[1][19:0] == 20'h5_5555 &&
                hist[2][19:0] == 20'hA_AA90;
    end
  end
  assign rd = !ceN && !oeN && weN;
  // read data: array pattern, or identification values after the prefix
  always @* begin
    if (!autoSel) val = addr[7:0] ^ 8'h3C;
    else begin
      case (addr[7:0])
        8'h00: val = MAKER_CODE;
        8'h02: val = PART_CODE;
        8'h04: val = {7'h00, addr[21]};
        8'h06: val = LOCK_CODE;
        default: val = 8'h00;
      endcase
    end
  end
  // released bus shows the inverse of the last value so a late sample cannot pass;
  // the address of the last read is kept for the bench to inspect
  always @(negedge rd) begin
    last = val;
    rdA = addr;
  end
  assign drv = rd ? val : ~last;
endmodule : fcs_flash_model

// *** test/tb_top.sv ***
`include "fcs_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  MAKER = 8'h5A;  // arbitrary value
  localparam logic [7:0]  PART  = 8'hC3;  // arbitrary value
  localparam logic [7:0]  LOCK  = 8'h85;
  localparam logic [21:0] U1    = `FCS_ADR_UNLK1;
  localparam logic [21:0] U2    = `FCS_ADR_UNLK2;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  logic             cmdValid = 1'b0;
  fcs_pkg::fcs_op_t cmdOp = fcs_pkg::OP_READ;
  logic [21:0]      cmdAddr = 22'h00_0000;
  logic [7:0]       cmdData = 8'h00;
  logic             cmdReady, rspValid, rspErr, bypassMode;
  logic             flashDqOe_n, flashCe_n, flashWe_n, flashOe_n;
  logic [7:0]       rspData, flashDqOut, flashDqIn, flashDrv;
  logic [21:0]      flashAddr;
  int               errors = 0;
  int               samples_checked = 0;
  int               cyc = 0;

  always #2 clk = ~clk;
  // host drive wins while enabled, otherwise the flash output
  assign flashDqIn = !flashDqOe_n ? flashDqOut : flashDrv;

  fcs_host dut (.clk, .nrst, .cmdValid, .cmdReady, .cmdOp, .cmdAddr, .cmdData, .rspValid,
    .rspErr, .rspData, .bypassMode, .flashAddr, .flashDqOut, .flashDqOe_n, .flashDqIn,
    .flashCe_n, .flashWe_n, .flashOe_n);
  fcs_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .LOCK_CODE(LOCK)) flash (
    .ceN(flashCe_n), .weN(flashWe_n), .oeN(flashOe_n), .addr(flashAddr), .dq(flashDqIn),
    .drv(flashDrv));

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [29:0] got, input logic [29:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one command; waits a bounded time for the answer pulse
  task automatic run(input fcs_pkg::fcs_op_t op, input logic [21:0] a, input logic [7:0] d,
                     input logic err);
    int n;
    n = 0;
    @(negedge clk);
    cmdValid = 1'b1;
    cmdOp = op;
    cmdAddr = a;
    cmdData = d;
    @(negedge clk);
    cmdValid = 1'b0;
    chk(cmdReady, err);
    while (rspValid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(rspValid, 1'b1);
    chk(rspErr, err);
  endtask : run

  // next write seen by the flash must match
  task automatic ew(input logic [21:0] a, input logic [7:0] d);
    logic [29:0] g;
    g = 'x;
    if (flash.wq.size() > 0) g = flash.wq.pop_front();
    chk(g, {a, d});
  endtask : ew

  task automatic unl();
    ew(U1, 8'hAA);
    ew(U2, 8'h55);
  endtask : unl

  task automatic t_program();
    run(fcs_pkg::OP_PROGRAM, 22'h12_3456, 8'hC5, 1'b0);
    unl();
    ew(U1, 8'hA0);
    ew(22'h12_3456, 8'hC5);
    $display("program test done");
  endtask : t_program

  task automatic t_erase();
    run(fcs_pkg::OP_CHIP_ERASE, 22'h00_0000, 8'h00, 1'b0);
    unl();
    ew(U1, 8'h80);
    unl();
    ew(U1, 8'h10);
    run(fcs_pkg::OP_SECT_ERASE, 22'h3F_1234, 8'h00, 1'b0);
    unl();
    ew(U1, 8'h80);
    unl();
    ew(22'h3F_0000, 8'h30);
    run(fcs_pkg::OP_SUSPEND, 22'h00_0000, 8'h00, 1'b0);
    ew(22'h00_0000, 8'hB0);
    run(fcs_pkg::OP_RESUME, 22'h00_0000, 8'h00, 1'b0);
    ew(22'h00_0000, 8'h30);
    $display("erase test done");
  endtask : t_erase

  task automatic t_autosel();
    logic [7:0] off[3];
    logic [7:0] exp[3];
    off = '{8'h00, 8'h02, 8'h06};
    exp = '{MAKER, PART, LOCK};
    for (int i = 0; i < 5; i++) begin
      if (i < 3) run(fcs_pkg::OP_AUTOSEL, {6'h3F, 8'h00, off[i]}, 8'h00, 1'b0);
      else run(fcs_pkg::OP_PROT, {i[0], 5'h05, 16'h0000}, 8'h00, 1'b0);
      unl();
      ew({i < 3 ? 1'b0 : i[0], 21'h00_0AAA}, 8'h90);
      chk(rspData, i < 3 ? exp[i] : {7'h00, i[0]});
      if (i < 3) chk(flash.rdA, {6'h00, 8'h00, off[i]});
      else chk(flash.rdA, {i[0], 5'h05, 16'h0004});
      ew(22'h00_0000, 8'hF0);
    end
    $display("autoselect test done");
  endtask : t_autosel

  task automatic t_bypass();
    run(fcs_pkg::OP_BYP_PROG, 22'h01_0010, 8'h3A, 1'b1);
    chk(30'(flash.wq.size()), 30'h0);
    run(fcs_pkg::OP_BYP_ENTER, 22'h00_0000, 8'h00, 1'b0);
    unl();
    ew(U1, 8'h20);
    @(negedge clk);
    chk(bypassMode, 1'b1);
    run(fcs_pkg::OP_SECT_ERASE, 22'h01_0000, 8'h00, 1'b1);
    run(fcs_pkg::OP_BYP_PROG, 22'h01_0010, 8'h3A, 1'b0);
    ew(22'h00_0000, 8'hA0);
    ew(22'h01_0010, 8'h3A);
    run(fcs_pkg::OP_BYP_RESET, 22'h00_0000, 8'h00, 1'b0);
    ew(22'h00_0000, 8'h90);
    ew(22'h00_0000, 8'h00);
    @(negedge clk);
    chk(bypassMode, 1'b0);
    $display("bypass test done");
  endtask : t_bypass

  task automatic t_misc();
    run(fcs_pkg::OP_RESET, 22'h00_0000, 8'h00, 1'b0);
    ew(22'h00_0000, 8'hF0);
    run(fcs_pkg::OP_SEC_ENTER, 22'h00_0000, 8'h00, 1'b0);
    unl();
    ew(U1, 8'h88);
    run(fcs_pkg::OP_SEC_EXIT, 22'h00_0000, 8'h00, 1'b0);
    unl();
    ew(U1, 8'h90);
    ew(22'h00_0000, 8'h00);
    run(fcs_pkg::OP_CFI, 22'h00_0000, 8'h00, 1'b0);
    ew(22'h00_00AA, 8'h98);
    run(fcs_pkg::OP_READ, 22'h2A_BC12, 8'h00, 1'b0);
    chk(rspData, 8'h12 ^ 8'h3C);
    chk(30'(flash.wq.size()), 30'h0);
    $display("misc test done");
  endtask : t_misc

  // hang guard, well above the roughly 1200 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_program();
    t_erase();
    t_autosel();
    t_bypass();
    t_misc();
    report_and_stop();
  end
endmodule : tb_top

bind fcs_host fcs_host_sva sva (.clk, .nrst, .cmdValid, .cmdReady, .cmdOp, .rspValid, .rspErr,
  .bypassMode, .flashAddr, .flashDqOut, .flashDqOe_n, .flashCe_n, .flashWe_n, .flashOe_n);
